// *** rtl/irq_route_dev.sv ***
// Purpose: wake detection, per-source enable/pending/priority and arbitration
// Assumes: sources synchronous to pclk; orders arrive on the link
// Notes:   request to the core is registered, one cycle behind pending
//
// Contract
// RULE1 - wake sources reach core only via detector
// RULE2 - software also sets wake detection for standby
// RULE3 - simultaneous requests: only highest priority presented
// RULE4 - core stacks context before routine starts
// RULE5 - disable, configure outward-in, then re-enable
// RULE6 - wake detect: preconditions, clear, then enable
// RULE7 - clear-enable one disables, zero ignored
// RULE8 - all sources disabled after reset
// RULE9 - sources drive requests per their type
// RULE10 - routine clears request at its source
// RULE11 - return resumes program, context restored
// RULE12 - request recognised on low-to-high transition
// RULE13 - three-bit priority, zero highest, low index wins
// RULE14 - latched wake edge held until cleared
// RULE15 - set-enable enables, clear-pending discards pending
// RULE16 - disabled source records pending, not presented
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "irq_route_cfg.svh"
module irq_route_dev
  import irq_route_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request sources
  input  wire logic [`NSRC-1:0]  src_in,
  // standby wake request
  output logic                   wake_out,
  // link to the core end
  irq_route_if.dev               lnk
);

  logic [`NSRC-1:0]         en_ff;
  logic [`NSRC-1:0]         pend_ff;
  logic [`NSRC-1:0]         src_d_ff;
  logic [`NSRC-1:0]         line_d_ff;
  logic [`NSRC-1:0]         wk_en_ff;
  logic [`NSRC-1:0]         wk_lat_ff;
  wake_mode_t               wk_mode_ff [`NSRC];
  logic [`PRIO_W-1:0]       prio_ff    [`NSRC];
  logic                     irq_req_ff;
  logic [`SRC_W-1:0]        irq_id_ff;
  logic [`PRIO_W-1:0]       irq_prio_ff;
  logic                     wake_ff;

  logic [`NSRC-1:0]         sel;
  logic [`NSRC-1:0]         set_en_hit;
  logic [`NSRC-1:0]         clr_en_hit;
  logic [`NSRC-1:0]         set_pend_hit;
  logic [`NSRC-1:0]         clr_pend_hit;
  logic [`NSRC-1:0]         ack_hit;
  logic [`NSRC-1:0]         wk_clr_hit;
  logic [`NSRC-1:0]         wk_edge;
  logic [`NSRC-1:0]         wk_line;
  logic [`NSRC-1:0]         line;
  logic [`NSRC-1:0]         line_rise;
  logic [`NSRC-1:0]         req_vec;
  logic                     nxt_req;
  logic [`SRC_W-1:0]        nxt_id;
  logic [`PRIO_W-1:0]       nxt_prio;

  function automatic logic [`NSRC-1:0] onehot(input logic [`SRC_W-1:0] idx);
    return `NSRC'(1) << idx;
  endfunction

  function automatic logic [`NSRC-1:0] op_hit(input cmd_op_t op);
    return (lnk.cmd_valid && lnk.cmd_op == op) ? sel : '0;
  endfunction

  // command decode
  always_comb begin
    sel          = onehot(lnk.cmd_src);
    set_en_hit   = op_hit(OP_SET_EN);
    clr_en_hit   = op_hit(OP_CLR_EN);
    set_pend_hit = op_hit(OP_SET_PEND);
    clr_pend_hit = op_hit(OP_CLR_PEND);
    wk_clr_hit   = op_hit(OP_WAKE_CLR);
    ack_hit      = lnk.irq_ack ? onehot(lnk.ack_id) : '0;
  end

  // wake detector and routing of each line toward the core
  always_comb begin
    for (int i = 0; i < `NSRC; i++) begin
      unique case (wk_mode_ff[i])
        WK_RISE: begin
          wk_edge[i] = wk_en_ff[i] & src_in[i] & ~src_d_ff[i];
          wk_line[i] = wk_lat_ff[i];
        end
        WK_FALL: begin
          wk_edge[i] = wk_en_ff[i] & ~src_in[i] & src_d_ff[i];
          wk_line[i] = wk_lat_ff[i];
        end
        WK_HIGH: begin
          wk_edge[i] = 1'b0;
          wk_line[i] = src_in[i];
        end
        WK_LOW: begin
          wk_edge[i] = 1'b0;
          wk_line[i] = ~src_in[i];
        end
      endcase
      line[i] = wk_en_ff[i] ? wk_line[i] : src_in[i]; // RULE1 RULE2
    end
    line_rise = line & ~line_d_ff; // RULE12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_ff  <= '0;
      line_d_ff <= '0;
    end else begin
      src_d_ff  <= src_in;
      line_d_ff <= line;
    end
  end

  // edge capture holds its line high until the clear order; a new edge wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_lat_ff <= '0;
    end else begin
      wk_lat_ff <= (wk_lat_ff & ~wk_clr_hit) | wk_edge; // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_en_ff <= '0;
      for (int i = 0; i < `NSRC; i++) begin
        wk_mode_ff[i] <= WK_RISE;
      end
    end else if (lnk.cmd_valid && lnk.cmd_op == OP_WAKE_CFG) begin
      wk_en_ff[lnk.cmd_src]   <= lnk.cmd_data[`WK_EN_BIT];
      wk_mode_ff[lnk.cmd_src] <= wake_mode_t'(lnk.cmd_data[`WK_MODE_LSB +: 2]);
    end
  end

  // enables start cleared; ones set or clear, zeros do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= '0; // RULE8
    end else begin
      en_ff <= (en_ff & ~clr_en_hit) | set_en_hit; // RULE7 RULE15
    end
  end

  // pending is kept whether or not enabled; a new edge beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~(clr_pend_hit | ack_hit)) | line_rise | set_pend_hit; // RULE15 RULE16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NSRC; i++) begin
        prio_ff[i] <= `PRIO_LOWEST;
      end
    end else if (lnk.cmd_valid && lnk.cmd_op == OP_SET_PRIO) begin
      prio_ff[lnk.cmd_src] <= lnk.cmd_data[`PRIO_W-1:0]; // RULE13
    end
  end

  // arbitration: lowest level wins, ties go to the lower index
  always_comb begin
    req_vec  = pend_ff & en_ff & ~ack_hit; // RULE16
    nxt_req  = 1'b0;
    nxt_id   = '0;
    nxt_prio = `PRIO_LOWEST;
    for (int i = 0; i < `NSRC; i++) begin
      if (req_vec[i] && (!nxt_req || prio_ff[i] < nxt_prio)) begin // RULE3 RULE13
        nxt_req  = 1'b1;
        nxt_id   = `SRC_W'(i);
        nxt_prio = prio_ff[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_ff  <= 1'b0;
      irq_id_ff   <= '0;
      irq_prio_ff <= '0;
    end else begin
      irq_req_ff  <= nxt_req; // RULE3
      irq_id_ff   <= nxt_id;
      irq_prio_ff <= nxt_prio;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= |(wk_en_ff & wk_line); // RULE1
    end
  end

  assign wake_out     = wake_ff;
  assign lnk.irq_req  = irq_req_ff;
  assign lnk.irq_id   = irq_id_ff;
  assign lnk.irq_prio = irq_prio_ff;
  assign lnk.pend_vec = pend_ff;
  assign lnk.en_vec   = en_ff;

endmodule // irq_route_dev

// *** include/irq_route_cfg.svh ***
// Purpose: named constants for the interrupt routing path
// Assumes: single clock pclk, 250 MHz
// Notes:   definitions only
`ifndef IRQ_ROUTE_CFG_SVH
`define IRQ_ROUTE_CFG_SVH

`define NSRC          8
`define SRC_W         3
`define PRIO_W        3
`define CMD_DATA_W    8
`define PRIO_LOWEST   3'h7
`define STACK_WORDS   4'h8
`define STACK_LAST    4'h7

// apb register offsets (paddr[7:0])
`define A_CMD         8'h00
`define A_STATUS      8'h04
`define A_PEND        8'h08
`define A_EN          8'h0c
`define A_EOI         8'h10
`define A_INT_STAT    8'h14
`define A_INT_MASK    8'h18

// command word fields
`define CMD_OP_LSB    0
`define CMD_SRC_LSB   4
`define CMD_DATA_LSB  8

// wake config data fields
`define WK_EN_BIT     0
`define WK_MODE_LSB   1

// status register fields
`define ST_STATE_LSB  0
`define ST_ID_LSB     4
`define ST_PRIO_LSB   8

// interrupt status bits
`define IRQ_ENTER_BIT 0
`define IRQ_RET_BIT   1
`define IRQ_BITS      2

`endif

// *** include/irq_route_pkg.sv ***
// Purpose: shared types of the interrupt routing path
// Assumes: nothing
// Notes:   encodings written out
package irq_route_pkg;

  typedef enum logic [2:0] {
    OP_SET_EN   = 3'h0,
    OP_CLR_EN   = 3'h1,
    OP_SET_PEND = 3'h2,
    OP_CLR_PEND = 3'h3,
    OP_SET_PRIO = 3'h4,
    OP_WAKE_CFG = 3'h5,
    OP_WAKE_CLR = 3'h6
  } cmd_op_t;

  typedef enum logic [1:0] {
    WK_RISE = 2'h0,
    WK_FALL = 2'h1,
    WK_HIGH = 2'h2,
    WK_LOW  = 2'h3
  } wake_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_STACK   = 2'h1,
    ST_ISR     = 2'h2,
    ST_UNSTACK = 2'h3
  } core_state_t;

endpackage

// *** include/irq_route_if.sv ***
// Purpose: link between the routing/controller end and the core end
// Assumes: both ends on pclk
// Notes:   no clocking block
`timescale 1ns/1ps
`include "irq_route_cfg.svh"
interface irq_route_if;
  import irq_route_pkg::*;
  // orders from the core end
  logic                    cmd_valid;
  cmd_op_t                 cmd_op;
  logic [`SRC_W-1:0]       cmd_src;
  logic [`CMD_DATA_W-1:0]  cmd_data;
  // request to the core and its ack back
  logic                    irq_req;
  logic [`SRC_W-1:0]       irq_id;
  logic [`PRIO_W-1:0]      irq_prio;
  logic                    irq_ack;
  logic [`SRC_W-1:0]       ack_id;
  // state shown back
  logic [`NSRC-1:0]        pend_vec;
  logic [`NSRC-1:0]        en_vec;

  modport dev  (input cmd_valid, cmd_op, cmd_src, cmd_data, irq_ack, ack_id,
                output irq_req, irq_id, irq_prio, pend_vec, en_vec);
  modport core (output cmd_valid, cmd_op, cmd_src, cmd_data, irq_ack, ack_id,
                input irq_req, irq_id, irq_prio, pend_vec, en_vec);
endinterface

// *** rtl/irq_core_end.sv ***
// Purpose: core side: takes requests, stacks, runs handler state, unstacks
// Assumes: software orders arrive over apb, one wait state per transfer
// Notes:   one request taken at a time
`timescale 1ns/1ps
`include "irq_route_cfg.svh"
module irq_core_end
  import irq_route_pkg::*;
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // interrupt to software
  output logic              irq_out,
  // link to the routing end
  irq_route_if.core         lnk
);

  core_state_t               state_ff;
  logic [3:0]                cnt_ff;
  logic [`SRC_W-1:0]         act_id_ff;
  logic [`PRIO_W-1:0]        act_prio_ff;
  logic                      ack_ff;
  logic                      cmd_valid_ff;
  cmd_op_t                   cmd_op_ff;
  logic [`SRC_W-1:0]         cmd_src_ff;
  logic [`CMD_DATA_W-1:0]    cmd_data_ff;
  logic [`IRQ_BITS-1:0]      int_stat_ff;
  logic [`IRQ_BITS-1:0]      int_mask_ff;
  logic                      pready_ff;
  logic                      pslverr_ff;
  logic [31:0]               prdata_ff;

  logic                      wr_done;
  logic                      take;
  logic                      eoi_wr;
  logic [`IRQ_BITS-1:0]      int_evt;
  logic                      mapped;
  logic [7:0]                addr;

  assign addr    = paddr[7:0];
  assign wr_done = psel & penable & pready_ff & pwrite;
  assign take    = state_ff == ST_IDLE && lnk.irq_req && !ack_ff;
  assign eoi_wr  = wr_done && addr == `A_EOI;

  always_comb begin
    unique case (addr)
      `A_CMD, `A_STATUS, `A_PEND, `A_EN, `A_EOI, `A_INT_STAT, `A_INT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // apb: one wait state, read data and error prepared in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
      if (psel && penable && !pready_ff && !pwrite) begin
        unique case (addr)
          `A_STATUS:   prdata_ff <= 32'({act_prio_ff, 1'b0, act_id_ff, 2'h0, state_ff});
          `A_PEND:     prdata_ff <= 32'(lnk.pend_vec);
          `A_EN:       prdata_ff <= 32'(lnk.en_vec);
          `A_INT_STAT: prdata_ff <= 32'(int_stat_ff);
          `A_INT_MASK: prdata_ff <= 32'(int_mask_ff);
          default:     prdata_ff <= '0;
        endcase
      end
    end
  end

  // software orders are forwarded as one-cycle commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid_ff <= 1'b0;
      cmd_op_ff    <= OP_SET_EN;
      cmd_src_ff   <= '0;
      cmd_data_ff  <= '0;
    end else begin
      cmd_valid_ff <= wr_done && addr == `A_CMD && pwdata[`CMD_OP_LSB +: 3] != 3'h7;
      if (wr_done && addr == `A_CMD) begin
        cmd_op_ff   <= cmd_op_t'(pwdata[`CMD_OP_LSB +: 3]); // RULE5 RULE6
        cmd_src_ff  <= pwdata[`CMD_SRC_LSB +: `SRC_W];
        cmd_data_ff <= pwdata[`CMD_DATA_LSB +: `CMD_DATA_W];
      end
    end
  end

  // entry stacks context words before the handler, return unstacks them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      act_id_ff   <= '0;
      act_prio_ff <= '0;
      ack_ff      <= 1'b0;
    end else begin
      ack_ff <= take;
      unique case (state_ff)
        ST_IDLE: begin
          if (take) begin
            state_ff    <= ST_STACK;
            cnt_ff      <= '0;
            act_id_ff   <= lnk.irq_id;
            act_prio_ff <= lnk.irq_prio;
          end
        end
        ST_STACK: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `STACK_LAST) begin
            state_ff <= ST_ISR; // RULE4
          end
        end
        ST_ISR: begin
          if (eoi_wr) begin
            state_ff <= ST_UNSTACK; // RULE10 RULE11
            cnt_ff   <= '0;
          end
        end
        ST_UNSTACK: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `STACK_LAST) begin
            state_ff <= ST_IDLE; // RULE11
          end
        end
      endcase
    end
  end

  always_comb begin
    int_evt = '0;
    int_evt[`IRQ_ENTER_BIT] = state_ff == ST_STACK && cnt_ff == `STACK_LAST;
    int_evt[`IRQ_RET_BIT]   = state_ff == ST_UNSTACK && cnt_ff == `STACK_LAST;
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_ff <= '0;
      int_mask_ff <= '0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~((wr_done && addr == `A_INT_STAT) ? pwdata[`IRQ_BITS-1:0] : '0)) | int_evt;
      if (wr_done && addr == `A_INT_MASK) begin
        int_mask_ff <= pwdata[`IRQ_BITS-1:0];
      end
    end
  end

  assign irq_out      = |(int_stat_ff & int_mask_ff);
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign lnk.cmd_valid = cmd_valid_ff;
  assign lnk.cmd_op    = cmd_op_ff;
  assign lnk.cmd_src   = cmd_src_ff;
  assign lnk.cmd_data  = cmd_data_ff;
  assign lnk.irq_ack   = ack_ff;
  assign lnk.ack_id    = act_id_ff;

endmodule // irq_core_end

// *** sim/irq_route_props.sv ***
// Purpose: assertions on the link between the routing end and the core end
// Assumes: one clock pclk, presetn async active low
// Notes:   priorities, enables and pending mirrored one cycle late
`timescale 1ns/1ps
`include "irq_route_cfg.svh"
module irq_route_props
  import irq_route_pkg::*;
(
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // orders
  input wire logic                  cmd_valid,
  input wire cmd_op_t               cmd_op,
  input wire logic [`SRC_W-1:0]     cmd_src,
  input wire logic [`CMD_DATA_W-1:0] cmd_data,
  // request and ack
  input wire logic                  irq_req,
  input wire logic [`SRC_W-1:0]     irq_id,
  input wire logic [`PRIO_W-1:0]    irq_prio,
  input wire logic                  irq_ack,
  input wire logic [`SRC_W-1:0]     ack_id,
  // state
  input wire logic [`NSRC-1:0]      pend_vec,
  input wire logic [`NSRC-1:0]      en_vec
);
  logic [`NSRC-1:0][`PRIO_W-1:0] prio_ff;
  logic [`NSRC-1:0][`PRIO_W-1:0] prio_q_ff;
  logic [`NSRC-1:0]              en_q_ff;
  logic [`NSRC-1:0]              pend_q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prio_ff <= {`NSRC{`PRIO_LOWEST}};
    else if (cmd_valid && cmd_op == OP_SET_PRIO) prio_ff[cmd_src] <= cmd_data[`PRIO_W-1:0];
  end

  // request stage sees state one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q_ff <= {`NSRC{`PRIO_LOWEST}};
      en_q_ff   <= 8'h00;
      pend_q_ff <= 8'h00;
    end else begin
      prio_q_ff <= prio_ff;
      en_q_ff   <= en_vec;
      pend_q_ff <= pend_vec;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take; irq_ack; endsequence
  sequence s_stack_quiet; !irq_ack [*8]; endsequence

  property p_en_reset; $rose(presetn) |-> en_vec == 8'h00; endproperty
  property p_set_en; cmd_valid && cmd_op == OP_SET_EN |=> en_vec[$past(cmd_src)]; endproperty
  property p_clr_en; cmd_valid && cmd_op == OP_CLR_EN |=> !en_vec[$past(cmd_src)]; endproperty
  property p_en_hold;
    !(cmd_valid && (cmd_op == OP_SET_EN || cmd_op == OP_CLR_EN)) |=> $stable(en_vec);
  endproperty
  property p_req_ok; irq_req |-> en_q_ff[irq_id] && pend_q_ff[irq_id]; endproperty
  property p_prio; irq_req |-> irq_prio == prio_q_ff[irq_id]; endproperty
  property p_ack; s_take |-> $past(irq_req) && ack_id == $past(irq_id); endproperty
  property p_stack; s_take |=> s_stack_quiet; endproperty

  a_en_reset: assert property (p_en_reset) else $error("enables not clear after reset");
  a_set_en: assert property (p_set_en) else $error("set enable missed");
  a_clr_en: assert property (p_clr_en) else $error("clear enable missed");
  a_en_hold: assert property (p_en_hold) else $error("enables moved without order");
  a_req_ok: assert property (p_req_ok) else $error("request from disabled or idle source");
  a_prio: assert property (p_prio) else $error("request priority wrong");
  a_ack: assert property (p_ack) else $error("ack without matching request");
  a_stack: assert property (p_stack) else $error("new ack during stacking");
endmodule // irq_route_props

// *** sim/interrupt_routing_enable_path_tb.sv ***
// Purpose: self-checking bench for both ends of the interrupt routing path
// Assumes: pclk 250 MHz, registers reached over apb
// Notes:   random sources from a fixed seed, ties and masking as corners
`timescale 1ns/1ps
`include "irq_route_cfg.svh"
module interrupt_routing_enable_path_tb
  import irq_route_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out, wake_out, e;
  logic [7:0]  src_in, m;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [2:0]  prio_tb [8];
  logic [2:0]  w;
  int          err_total, cmp_count, i, k;
  integer      seed;

  irq_route_if lnk_if();
  irq_route_dev irq_route_dev_inst (.pclk(pclk), .presetn(presetn), .src_in(src_in), .wake_out(wake_out),
    .lnk(lnk_if));
  irq_core_end irq_core_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_out(irq_out), .lnk(lnk_if));
  irq_route_props irq_route_props_inst (.pclk(pclk), .presetn(presetn), .cmd_valid(lnk_if.cmd_valid),
    .cmd_op(lnk_if.cmd_op), .cmd_src(lnk_if.cmd_src), .cmd_data(lnk_if.cmd_data), .irq_req(lnk_if.irq_req),
    .irq_id(lnk_if.irq_id), .irq_prio(lnk_if.irq_prio), .irq_ack(lnk_if.irq_ack), .ack_id(lnk_if.ack_id),
    .pend_vec(lnk_if.pend_vec), .en_vec(lnk_if.en_vec));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic close_out();
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= {24'h000000, a}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic cmd(input cmd_op_t op, input logic [2:0] s, input logic [7:0] d);
    apb(1'b1, `A_CMD, {16'h0000, d, 1'b0, s, 1'b0, op});
  endtask

  // poll until the core end reaches the given state
  task automatic wait_state(input logic [1:0] st);
    int n;
    n = 0;
    do begin apb(1'b0, `A_STATUS, 32'h0); n++; end while (r[1:0] !== st && n < 40);
    chk("state", {30'h0, st}, {30'h0, r[1:0]});
  endtask

  // lowest priority value wins, lowest index on a tie
  function automatic logic [2:0] win(input logic [7:0] v);
    logic [3:0] bp;
    logic [2:0] b;
    bp = 4'h8;
    b = 3'h0;
    for (int j = 0; j < 8; j++) if (v[j] && {1'b0, prio_tb[j]} < bp) begin bp = {1'b0, prio_tb[j]}; b = j[2:0]; end
    return b;
  endfunction

  // run takes just over a thousand cycles; 50000 cycles means a hang
  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    seed = 32'h7e7625de;
    err_total = 0; cmp_count = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; src_in = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `A_EN, 32'h0); chk("en_reset", 32'h0, r);
    apb(1'b0, 8'h1c, 32'h0); chk("unmapped", 32'h1, {31'h0, e});
    m = 8'($random(seed));
    for (i = 0; i < 8; i++) cmd(OP_SET_EN, i[2:0], 8'h00);
    apb(1'b0, `A_EN, 32'h0); chk("en_all", 32'hff, r);
    for (i = 0; i < 8; i++) if (m[i]) cmd(OP_CLR_EN, i[2:0], 8'h00);
    apb(1'b0, `A_EN, 32'h0); chk("en_part", {24'h0, ~m}, r);
    for (i = 0; i < 8; i++) cmd(OP_CLR_EN, i[2:0], 8'h00);
    m = 8'($random(seed)) | 8'h01;
    @(posedge pclk) src_in <= m;
    repeat (3) @(posedge pclk);
    apb(1'b0, `A_PEND, 32'h0); chk("pend_dis", {24'h0, m}, r);
    chk("req_dis", 32'h0, {31'h0, lnk_if.irq_req});
    w = 3'($random(seed));
    cmd(OP_CLR_PEND, w, 8'h00);
    apb(1'b0, `A_PEND, 32'h0); chk("pend_clr", {24'h0, m & ~(8'h01 << w)}, r);
    for (i = 0; i < 8; i++) cmd(OP_CLR_PEND, i[2:0], 8'h00);
    @(posedge pclk) src_in <= 8'h00;
    for (i = 0; i < 8; i++) cmd(OP_SET_EN, i[2:0], 8'h00);
    for (k = 0; k < 6; k++) begin
      apb(1'b1, `A_INT_MASK, (k == 1) ? 32'h2 : 32'h3);
      for (i = 0; i < 8; i++) begin
        prio_tb[i] = (k == 0) ? 3'h3 : 3'($random(seed));
        cmd(OP_SET_PRIO, i[2:0], {5'h00, prio_tb[i]});
      end
      m = (k == 0) ? 8'hff : 8'($random(seed));
      if (m == 8'h00) m = 8'h80;
      @(posedge pclk) src_in <= m;
      wait_state(ST_ISR);
      chk("win_id", {29'h0, win(m)}, {29'h0, r[6:4]});
      chk("win_prio", {29'h0, prio_tb[win(m)]}, {29'h0, r[10:8]});
      chk("irq_enter", (k == 1) ? 32'h0 : 32'h1, {31'h0, irq_out});
      for (i = 0; i < 8; i++) cmd(OP_CLR_PEND, i[2:0], 8'h00);
      @(posedge pclk) src_in <= 8'h00;
      apb(1'b1, `A_EOI, 32'h0);
      wait_state(ST_IDLE);
      apb(1'b0, `A_INT_STAT, 32'h0); chk("int_stat", 32'h3, r);
      apb(1'b1, `A_INT_STAT, 32'h3);
      apb(1'b0, `A_INT_STAT, 32'h0); chk("int_w1c", 32'h0, r);
      chk("irq_low", 32'h0, {31'h0, irq_out});
    end
    cmd(OP_CLR_EN, 3'h5, 8'h00);
    cmd(OP_WAKE_CFG, 3'h5, 8'h01);
    cmd(OP_WAKE_CLR, 3'h5, 8'h00);
    @(posedge pclk) src_in <= 8'h20;
    @(posedge pclk) src_in <= 8'h00;
    repeat (4) @(posedge pclk);
    chk("wake_held", 32'h1, {31'h0, wake_out});
    apb(1'b0, `A_PEND, 32'h0); chk("wake_pend", 32'h20, r);
    cmd(OP_WAKE_CLR, 3'h5, 8'h00);
    repeat (3) @(posedge pclk);
    chk("wake_clr", 32'h0, {31'h0, wake_out});
    for (i = 0; i < 8; i++) cmd(OP_CLR_EN, i[2:0], 8'h00);
    for (i = 0; i < 8; i++) cmd(OP_CLR_PEND, i[2:0], 8'h00);
    // fall, high and low detector modes on sources 2 to 4
    for (k = 1; k < 4; k++) begin
      w = 3'(k + 1);
      cmd(OP_WAKE_CFG, w, {5'h00, k[1:0], 1'b1});
      cmd(OP_WAKE_CLR, w, 8'h00);
      if (k != 3) @(posedge pclk) src_in <= 8'h01 << w;
      if (k == 1) @(posedge pclk) src_in <= 8'h00;
      repeat (4) @(posedge pclk);
      chk("wake_mode_on", 32'h1, {31'h0, wake_out});
      apb(1'b0, `A_PEND, 32'h0); chk("wake_mode_pend", 32'(8'h01 << w), r);
      if (k == 1) cmd(OP_WAKE_CLR, w, 8'h00);
      else @(posedge pclk) src_in <= (k == 2) ? 8'h00 : 8'h01 << w;
      repeat (3) @(posedge pclk);
      chk("wake_mode_off", 32'h0, {31'h0, wake_out});
      cmd(OP_WAKE_CFG, w, 8'h00);
      @(posedge pclk) src_in <= 8'h00;
      cmd(OP_CLR_PEND, w, 8'h00);
    end
    // software-raised request waits for its enable
    cmd(OP_SET_PEND, 3'h6, 8'h00);
    repeat (3) @(posedge pclk);
    apb(1'b0, `A_PEND, 32'h0); chk("set_pend", 32'h40, r);
    chk("set_pend_req", 32'h0, {31'h0, lnk_if.irq_req});
    cmd(OP_SET_EN, 3'h6, 8'h00);
    wait_state(ST_ISR);
    chk("set_pend_id", 32'h6, {29'h0, r[6:4]});
    apb(1'b1, `A_EOI, 32'h0);
    wait_state(ST_IDLE);
    apb(1'b0, `A_PEND, 32'h0); chk("ack_clears", 32'h0, r);
    apb(1'b1, `A_EOI, 32'h0);
    apb(1'b0, `A_STATUS, 32'h0); chk("eoi_idle", 32'h0, {30'h0, r[1:0]});
    close_out();
  end
endmodule // interrupt_routing_enable_path_tb
